// >>> src/bmcd_pkg.sv
package bmcd_pkg;
	// Frame byte and bit positions
	localparam int FRM_BYTES = 8;
	localparam int B0_SERVO_ON = 1;
	localparam int B2_JOG = 3;
	localparam int B2_STEP = 4;
	localparam int B2_STATION = 5;
	localparam int B3_INC = 0;
	localparam int B3_DIR = 1;
	// Register offsets (word index)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STEP0 = 4'h1;
	localparam logic [3:0] REG_STEP1 = 4'h2;
	localparam logic [3:0] REG_STEP2 = 4'h3;
	localparam logic [3:0] REG_STEP3 = 4'h4;
	localparam logic [3:0] REG_STATIONS = 4'h5;
	localparam logic [3:0] REG_STEPS_REV = 4'h6;
	localparam logic [3:0] REG_STATUS = 4'h7;
	localparam logic [3:0] REG_POS = 4'h8;
	// Control register fields
	localparam int CTRL_JOG_UNIT = 0;
	localparam int CTRL_STN_DIR = 1;
	localparam int CTRL_COORD = 2;
	// Limits and reset values
	localparam logic [31:0] STEP_MAX = 32'h05F5_E0FF;
	localparam logic [31:0] STEP0_RST = 32'h0000_0001;
	localparam logic [31:0] STEP1_RST = 32'h0000_000A;
	localparam logic [31:0] STEP2_RST = 32'h0000_0064;
	localparam logic [31:0] STEP3_RST = 32'h0000_03E8;
	localparam logic [15:0] STN_MAX = 16'h7FFF;
	localparam logic [15:0] STN_RST = 16'h0001;
	localparam logic [31:0] STEPS_REV_RST = 32'h0005_7E40;
	localparam logic [31:0] STEPS_REV_MAX = 32'h0016_E360;
	localparam logic [31:0] SPEED_MAX = 32'h0003_A980;
	localparam logic [3:0] CODE_BIT_MOVE = 4'h0;
	localparam int DIV_STEPS = 40;

	typedef enum logic [3:0] {
		BMCD_IDLE = 4'b0001,
		BMCD_JOG = 4'b0010,
		BMCD_DIV = 4'b0100,
		BMCD_MOVE = 4'b1000
	} bmcd_state_t;

	typedef enum logic [1:0] {
		BMCD_K_NONE = 2'd0,
		BMCD_K_JOG = 2'd1,
		BMCD_K_STEP = 2'd2,
		BMCD_K_STN = 2'd3
	} bmcd_kind_t;

	// Motion request to the profile generator
	typedef struct packed {
		bmcd_kind_t kind;
		logic jog_run;
		logic dir_neg;
		logic use_jog_speed;
		logic override_is_speed;
		logic [31:0] override_val;
		logic [31:0] distance;
	} bmcd_req_t;
endpackage

// >>> src/bmcd_step_mem.sv
`timescale 1ns/1ps
module bmcd_step_mem import bmcd_pkg::*; #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Write side
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read side, registered
	input wire logic [1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_q [4];

	always_ff @(posedge clk) begin
		if (srst) begin
			mem_q[0] <= W'(STEP0_RST);
			mem_q[1] <= W'(STEP1_RST);
			mem_q[2] <= W'(STEP2_RST);
			mem_q[3] <= W'(STEP3_RST);
		end else if (we) begin
			mem_q[waddr] <= (wdata > W'(STEP_MAX)) ? W'(STEP_MAX) : wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= '0;
		end else begin
			rdata <= mem_q[raddr];
		end
	end
endmodule

// >>> src/bmcd_divider.sv
`timescale 1ns/1ps
module bmcd_divider import bmcd_pkg::*; #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Request
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	// Result
	output logic busy,
	output logic [W-1:0] quotient
);
	// Bit-serial restoring divide; slow but tiny, stations are rare
	logic [W-1:0] rem_q;
	logic [W-1:0] den_q;
	logic [5:0] cnt_q;
	logic [W:0] trial;

	always_comb begin
		trial = {rem_q, quotient[W-1]} - {1'b0, den_q};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
			cnt_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			quotient <= '0;
		end else if (start) begin
			busy <= 1'b1;
			cnt_q <= 6'(W);
			rem_q <= '0;
			den_q <= divisor;
			quotient <= dividend;
		end else if (busy) begin
			if (trial[W]) begin
				rem_q <= {rem_q[W-2:0], quotient[W-1]};
				quotient <= {quotient[W-2:0], 1'b0};
			end else begin
				rem_q <= trial[W-1:0];
				quotient <= {quotient[W-2:0], 1'b1};
			end
			cnt_q <= cnt_q - 6'd1;
			busy <= (cnt_q != 6'd1);
		end
	end
endmodule

// >>> src/bmcd_top.sv
// What this block does
// - Direction taken from byte 3 bit 1
// - Jog starts on byte 2 bit 3
// - Override read as ratio or speed
// - Jog runs while bit held, stops after
// - Step starts on byte 2 bit 4
// - Step travels selected distance then stops
// - Byte 4 selects one of four distances
// - Four distances, capped, defaults 1/10/100/1000
// - Stations per revolution 1 to 32767
// - Station move starts on byte 2 bit 5
// - Station direction setting 1 takes shortest path
// - Byte 3 bit 0 absolute or incremental
// - Station moves use positioning profile settings
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module bmcd_top import bmcd_pkg::*; #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Remote output frame
	input wire logic [FRM_BYTES*8-1:0] frame,
	input wire logic move_done,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Motion request
	output bmcd_req_t req_q,
	output logic start_q,
	output logic busy_q,
	output logic [5:0] resp_type_q
);
	function automatic logic [7:0] fbyte(input logic [FRM_BYTES*8-1:0] f, input int n);
		fbyte = f[n*8 +: 8];
	endfunction

	logic [7:0] b0, b1, b2, b3;
	logic [31:0] operand;
	logic servo_on, code_ok, jog_bit, step_bit, stn_bit;
	assign b0 = fbyte(frame, 0);
	assign b1 = fbyte(frame, 1);
	assign b2 = fbyte(frame, 2);
	assign b3 = fbyte(frame, 3);
	assign operand = frame[63:32];
	assign servo_on = b0[B0_SERVO_ON];
	assign code_ok = (b1[3:0] == CODE_BIT_MOVE);
	assign jog_bit = servo_on && code_ok && b2[B2_JOG];
	assign step_bit = servo_on && code_ok && b2[B2_STEP];
	assign stn_bit = servo_on && code_ok && b2[B2_STATION];

	// Configuration registers
	logic [2:0] ctrl_q;
	logic [15:0] stations_q;
	logic [31:0] steps_rev_q;
	logic [15:0] cur_stn_q;
	logic [1:0] err_q;
	logic step_we;
	logic [31:0] step_rd;
	logic [1:0] step_raddr;
	logic [7:0] b2_prev_q;

	assign step_we = reg_wr && (reg_addr >= REG_STEP0) && (reg_addr <= REG_STEP3);

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= '0;
			stations_q <= STN_RST;
			steps_rev_q <= STEPS_REV_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: ctrl_q <= reg_wdata[2:0];
				REG_STATIONS: begin
					// Zero would divide by zero; clamp into range
					if (reg_wdata[15:0] == 16'h0000) begin
						stations_q <= STN_RST;
					end else if (reg_wdata[15:0] > STN_MAX) begin
						stations_q <= STN_MAX;
					end else begin
						stations_q <= reg_wdata[15:0];
					end
				end
				REG_STEPS_REV: begin
					if (reg_wdata == 32'h0000_0000) begin
						steps_rev_q <= STEPS_REV_RST;
					end else if (reg_wdata > STEPS_REV_MAX) begin
						steps_rev_q <= STEPS_REV_MAX;
					end else begin
						steps_rev_q <= reg_wdata;
					end
				end
				default: ;
			endcase
		end
	end

	bmcd_state_t state_q;
	logic div_start, div_busy;
	logic [31:0] div_q;
	logic [31:0] stn_target_q;
	logic stn_dir_neg_q;

	bmcd_step_mem #(.W(32)) bmcd_step_mem_inst (
		.clk(clk),
		.srst(srst),
		.we(step_we),
		.waddr(2'(reg_addr - REG_STEP0)),
		.wdata(reg_wdata),
		.raddr(step_raddr),
		.rdata(step_rd)
	);

	// Steps per station
	bmcd_divider #(.W(32)) bmcd_divider_inst (
		.clk(clk),
		.srst(srst),
		.start(div_start),
		.dividend(steps_rev_q),
		.divisor({16'h0000, stations_q}),
		.busy(div_busy),
		.quotient(div_q)
	);

	// Memory port takes step selection when idle, else reg_addr; step_rd never reaches reg_rdata
	assign step_raddr = (state_q == BMCD_IDLE) ? operand[1:0] : 2'(reg_addr - REG_STEP0);

	logic rise_step, rise_stn;
	assign rise_step = step_bit && !b2_prev_q[B2_STEP];
	assign rise_stn = stn_bit && !b2_prev_q[B2_STATION];
	assign div_start = (state_q == BMCD_IDLE) && !jog_bit && !rise_step && rise_stn;

	logic step_pend_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			b2_prev_q <= '0;
		end else begin
			b2_prev_q <= b2 & {8{servo_on && code_ok}};
		end
	end

	// Station target count and shortest-path choice
	logic [15:0] stn_abs;
	logic [15:0] stn_delta;
	logic stn_fwd_short;
	always_comb begin
		stn_abs = b3[B3_INC] ? 16'(cur_stn_q + operand[15:0]) : operand[15:0];
		if (stn_abs >= stations_q) begin
			stn_abs = 16'(stn_abs - stations_q);
		end
		stn_delta = (stn_abs >= cur_stn_q) ? 16'(stn_abs - cur_stn_q) : 16'(stn_abs + stations_q - cur_stn_q);
		stn_fwd_short = ({stn_delta, 1'b0} <= {1'b0, stations_q});
	end

	logic [15:0] stn_move_cnt_q;
	logic [63:0] stn_dist_full;
	assign stn_dist_full = div_q * {48'h0, stn_move_cnt_q};

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= BMCD_IDLE;
			req_q <= '0;
			start_q <= 1'b0;
			busy_q <= 1'b0;
			resp_type_q <= '0;
			step_pend_q <= 1'b0;
			stn_move_cnt_q <= '0;
			stn_target_q <= '0;
			stn_dir_neg_q <= 1'b0;
			cur_stn_q <= '0;
			err_q <= '0;
		end else begin
			start_q <= 1'b0;
			resp_type_q <= {2'b00, b1[7:4]};
			// Clear-on-write first, so a same-cycle event wins
			if (reg_wr && reg_addr == REG_STATUS) begin
				err_q <= err_q & ~reg_wdata[1:0];
			end
			unique case (state_q)
				BMCD_IDLE: begin
					busy_q <= 1'b0;
					step_pend_q <= 1'b0;
					if (jog_bit) begin
						state_q <= BMCD_JOG;
						busy_q <= 1'b1;
						start_q <= 1'b1;
						req_q.kind <= BMCD_K_JOG;
						req_q.jog_run <= 1'b1;
						req_q.dir_neg <= b3[B3_DIR];
						req_q.use_jog_speed <= 1'b1;
						req_q.override_is_speed <= ctrl_q[CTRL_JOG_UNIT];
						req_q.override_val <= (ctrl_q[CTRL_JOG_UNIT] && operand > SPEED_MAX) ? SPEED_MAX : operand;
					end else if (rise_step) begin
						step_pend_q <= 1'b1;
						state_q <= BMCD_MOVE;
						busy_q <= 1'b1;
						req_q.kind <= BMCD_K_STEP;
						req_q.dir_neg <= b3[B3_DIR];
						req_q.jog_run <= 1'b0;
						req_q.use_jog_speed <= 1'b0;
					end else if (rise_stn) begin
						state_q <= BMCD_DIV;
						busy_q <= 1'b1;
						stn_target_q <= {16'h0000, stn_abs};
						stn_move_cnt_q <= (ctrl_q[CTRL_STN_DIR] && !stn_fwd_short) ? 16'(stations_q - stn_delta)
							: (ctrl_q[CTRL_STN_DIR] || !b3[B3_DIR]) ? stn_delta
							: ((stn_delta == 16'h0000) ? 16'h0000 : 16'(stations_q - stn_delta));
						stn_dir_neg_q <= ctrl_q[CTRL_STN_DIR] ? !stn_fwd_short : b3[B3_DIR];
					end
				end
				BMCD_JOG: begin
					// Speed override may change while jogging
					req_q.override_val <= (ctrl_q[CTRL_JOG_UNIT] && operand > SPEED_MAX) ? SPEED_MAX : operand;
					if (!jog_bit) begin
						req_q.jog_run <= 1'b0;
						state_q <= BMCD_MOVE;
					end
				end
				BMCD_DIV: begin
					if (!div_busy && !div_start) begin
						start_q <= 1'b1;
						state_q <= BMCD_MOVE;
						req_q.kind <= BMCD_K_STN;
						req_q.jog_run <= 1'b0;
						req_q.dir_neg <= stn_dir_neg_q;
						req_q.use_jog_speed <= 1'b0;
						if (stn_dist_full > {32'h0, STEP_MAX}) begin
							err_q[1] <= 1'b1;
							req_q.distance <= STEP_MAX;
						end else begin
							req_q.distance <= stn_dist_full[31:0];
						end
						cur_stn_q <= stn_target_q[15:0];
					end
				end
				BMCD_MOVE: begin
					// Memory read lands one cycle after selection
					if (step_pend_q) begin
						step_pend_q <= 1'b0;
						start_q <= 1'b1;
						req_q.distance <= step_rd;
					end else if (move_done) begin
						state_q <= BMCD_IDLE;
						req_q.kind <= BMCD_K_NONE;
					end
				end
				default: state_q <= BMCD_IDLE;
			endcase
			if (state_q == BMCD_IDLE && (b2[B2_JOG] || b2[B2_STEP] || b2[B2_STATION]) && !servo_on) begin
				err_q[0] <= 1'b1;
			end
		end
	end

	logic [2:0] onehot_cmds;
	assign onehot_cmds = {b2[B2_STATION], b2[B2_STEP], b2[B2_JOG]};

	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: reg_rdata <= {29'h0, ctrl_q};
				REG_STATIONS: reg_rdata <= {16'h0, stations_q};
				REG_STEPS_REV: reg_rdata <= steps_rev_q;
				REG_STATUS: reg_rdata <= {24'h0, onehot_cmds, state_q != BMCD_IDLE, busy_q, 1'b0, err_q};
				REG_POS: reg_rdata <= {16'h0, cur_stn_q};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// Jog request tracks the jog bit
	property p_jog_start;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && jog_bit) |=> (start_q && req_q.kind == BMCD_K_JOG && req_q.jog_run);
	endproperty
	a_jog_start: assert property (p_jog_start) else $error("jog not started");

	property p_jog_dir;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && jog_bit) |=> (req_q.dir_neg == $past(b3[B3_DIR]));
	endproperty
	a_jog_dir: assert property (p_jog_dir) else $error("jog direction wrong");

	property p_jog_stop;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_JOG && !jog_bit) |=> (!req_q.jog_run && state_q == BMCD_MOVE);
	endproperty
	a_jog_stop: assert property (p_jog_stop) else $error("jog did not stop");

	property p_jog_unit;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && jog_bit) |=> (req_q.override_is_speed == $past(ctrl_q[CTRL_JOG_UNIT]));
	endproperty
	a_jog_unit: assert property (p_jog_unit) else $error("jog unit wrong");

	property p_step_start;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && !jog_bit && rise_step) |=> ##1 (start_q && req_q.kind == BMCD_K_STEP);
	endproperty
	a_step_start: assert property (p_step_start) else $error("step not started");

	property p_stn_start;
		@(posedge clk) disable iff (srst)
		div_start |=> ##[1:40] (start_q && req_q.kind == BMCD_K_STN);
	endproperty
	a_stn_start: assert property (p_stn_start) else $error("station move not started");

	property p_no_servo;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && !servo_on) |=> !start_q;
	endproperty
	a_no_servo: assert property (p_no_servo) else $error("move without servo on");

	property p_stn_range;
		@(posedge clk) disable iff (srst)
		(stations_q != 16'h0000) && (stations_q <= STN_MAX);
	endproperty
	a_stn_range: assert property (p_stn_range) else $error("stations out of range");

	property p_step_dist;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_MOVE && step_pend_q) |=> (start_q && req_q.distance == $past(step_rd));
	endproperty
	a_step_dist: assert property (p_step_dist) else $error("step distance not issued");

	property p_code_gate;
		@(posedge clk) disable iff (srst)
		(state_q == BMCD_IDLE && b1[3:0] != CODE_BIT_MOVE) |=> !start_q;
	endproperty
	a_code_gate: assert property (p_code_gate) else $error("move started with wrong code");
endmodule

// >>> testbench/bmcd_master_model.sv
`timescale 1ns/1ps
module bmcd_master_model import bmcd_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Wanted command
	input wire logic servo,
	input wire logic cmd_en,
	input wire logic [1:0] kind,
	input wire logic dir,
	input wire logic inc,
	input wire logic [31:0] operand,
	input wire logic [3:0] resp,
	input wire logic [3:0] code,
	// Output frame
	output logic [FRM_BYTES*8-1:0] frame
);
	logic cmd_q;

	// Command bit lags one cycle so operands settle first
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_q <= 1'b0;
		end else begin
			cmd_q <= cmd_en;
		end
	end

	always_comb begin
		frame = '0;
		frame[B0_SERVO_ON] = servo;
		frame[15:8] = {resp, code};
		frame[16+B2_JOG] = cmd_q && (kind == BMCD_K_JOG);
		frame[16+B2_STEP] = cmd_q && (kind == BMCD_K_STEP);
		frame[16+B2_STATION] = cmd_q && (kind == BMCD_K_STN);
		frame[24+B3_INC] = inc;
		frame[24+B3_DIR] = dir;
		// Caller keeps speed and relative counts within limits
		frame[63:32] = operand;
	end
endmodule

// >>> testbench/bmcd_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module bmcd_top_tb import bmcd_pkg::*;;
	logic clk = 0, srst = 1, servo = 0, cmd_en = 0, dir = 0, inc = 0, move_done = 0, reg_wr = 0, reg_rd = 0, ok;
	logic [1:0] kind = 0;
	logic [3:0] resp = 0, code = 0, reg_addr = 0;
	logic [31:0] operand = 0, reg_wdata = 0, reg_rdata, d;
	logic [63:0] frame;
	logic [5:0] resp_type_q;
	logic [31:0] dist_exp [4];
	bmcd_req_t req_q;
	logic start_q, busy_q;
	int err_count = 0, checks = 0, u, s;

	always #12.5 clk = ~clk;

	bmcd_master_model bmcd_master_model_inst (.clk(clk), .srst(srst), .servo(servo), .cmd_en(cmd_en), .kind(kind),
		.dir(dir), .inc(inc), .operand(operand), .resp(resp), .code(code), .frame(frame));
	bmcd_top bmcd_top_inst (.clk(clk), .srst(srst), .frame(frame), .move_done(move_done), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_q(req_q),
		.start_q(start_q), .busy_q(busy_q), .resp_type_q(resp_type_q));

	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask

	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask

	// Raise a command and wait a bounded time for the request pulse
	task go(input logic [1:0] k, input logic dr, input logic ic, input logic [31:0] op, output logic hit);
		int n;
		@(posedge clk);
		kind <= k;
		dir <= dr;
		inc <= ic;
		operand <= op;
		cmd_en <= 1;
		hit = 0;
		for (n = 0; n < 100 && !hit; n++) begin
			@(posedge clk);
			#1 hit = (start_q === 1'b1);
		end
	endtask

	task stop;
		int n;
		@(posedge clk);
		cmd_en <= 0;
		repeat (3) @(posedge clk);
		#1 `CHK(req_q.jog_run, 1'b0)
		@(posedge clk);
		move_done <= 1;
		@(posedge clk);
		move_done <= 0;
		for (n = 0; n < 10; n++) begin
			@(posedge clk);
			#1 if (busy_q === 1'b0) break;
		end
		`CHK(busy_q, 1'b0)
	endtask

	task print_verdict;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#500000;
		err_count++;
		print_verdict();
	end

	initial begin
		dist_exp = '{STEP0_RST, STEP1_RST, STEP_MAX, STEP3_RST};
		repeat (6) @(posedge clk);
		srst <= 0;
		rd(REG_CTRL, d); `CHK(d, 32'h0000_0000)
		rd(REG_STATIONS, d); `CHK(d, {16'h0000, STN_RST})
		rd(REG_STEPS_REV, d); `CHK(d, STEPS_REV_RST)
		rd(REG_STEP0, d); `CHK(d, 32'h0000_0000)
		rd(4'hF, d); `CHK(d, 32'h0000_0000)
		@(posedge clk);
		servo <= 1;
		resp <= 4'hA;
		// Ratio then speed override, speed at its ceiling
		for (u = 0; u < 2; u++) begin
			wr(REG_CTRL, u);
			go(BMCD_K_JOG, 1, 0, u ? SPEED_MAX : 32'h0000_0032, ok);
			`CHK(ok, 1'b1)
			`CHK(req_q.kind, BMCD_K_JOG)
			`CHK(req_q.jog_run, 1'b1)
			`CHK(req_q.dir_neg, 1'b1)
			`CHK(req_q.override_is_speed, u[0])
			`CHK(req_q.use_jog_speed, 1'b1)
			`CHK(req_q.override_val, u ? SPEED_MAX : 32'h0000_0032)
			stop();
		end
		`CHK(resp_type_q, 6'h0A)
		wr(REG_CTRL, 0);
		// Oversized distance is held at the ceiling
		wr(REG_STEP2, 32'hFFFF_FFFF);
		for (s = 0; s < 4; s++) begin
			go(BMCD_K_STEP, s[0], 0, s, ok);
			`CHK(ok, 1'b1)
			`CHK(req_q.kind, BMCD_K_STEP)
			`CHK(req_q.dir_neg, s[0])
			`CHK(req_q.distance, dist_exp[s])
			stop();
		end
		// Four stations, 90000 steps each
		wr(REG_STATIONS, 4);
		go(BMCD_K_STN, 0, 1, 2, ok);
		`CHK(ok, 1'b1)
		`CHK(req_q.kind, BMCD_K_STN)
		`CHK(req_q.use_jog_speed, 1'b0)
		`CHK(req_q.distance, 32'h0002_BF20)
		stop();
		rd(REG_POS, d); `CHK(d, 32'h0000_0002)
		go(BMCD_K_STN, 0, 0, 3, ok);
		`CHK(req_q.distance, 32'h0001_5F90)
		stop();
		rd(REG_POS, d); `CHK(d, 32'h0000_0003)
		// Shortest path wraps forward, direction bit ignored
		wr(REG_CTRL, 2);
		go(BMCD_K_STN, 1, 0, 0, ok);
		`CHK(req_q.dir_neg, 1'b0)
		`CHK(req_q.distance, 32'h0001_5F90)
		stop();
		wr(REG_CTRL, 0);
		servo <= 0;
		go(BMCD_K_JOG, 0, 0, 50, ok);
		`CHK(ok, 1'b0)
		rd(REG_STATUS, d); `CHK(d[0], 1'b1)
		@(posedge clk);
		cmd_en <= 0;
		servo <= 1;
		code <= 4'h1;
		repeat (4) @(posedge clk);
		go(BMCD_K_STEP, 0, 0, 0, ok);
		`CHK(ok, 1'b0)
		wr(REG_STATUS, 32'h0000_0001);
		rd(REG_STATUS, d); `CHK(d[0], 1'b0)
		print_verdict();
	end
endmodule
